/* hw/capture_channel.sv */
`timescale 1ns/1ps
module capture_channel (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control and results
   capture_if.chan  ch
);
   logic        trig_reg,     trig_next;
   logic        running_reg,  running_next;
   logic        captured_reg, captured_next;
   logic [31:0] latched_reg,  latched_next;
   logic [15:0] count_reg,    count_next;
   logic        hit;

   always_comb begin
      // edge select applies at once, no latching of the setting
      hit = ch.edge_rising ? (ch.trig & ~trig_reg) : (~ch.trig & trig_reg);
      trig_next     = ch.trig;
      running_next  = running_reg;
      captured_next = captured_reg;
      latched_next  = latched_reg;
      count_next    = count_reg;
      if (ch.rearm) begin
         running_next  = (ch.mode != 2'(capture_pkg::arm_stop));
         captured_next = 1'b0;
         if (ch.mode != 2'(capture_pkg::arm_stop)) begin
            count_next = 16'h0000;
         end
      end else if (running_reg && hit) begin
         latched_next  = ch.position;
         captured_next = 1'b1;
         count_next    = count_reg + 16'h0001;
         running_next  = (ch.mode == 2'(capture_pkg::arm_continuous));
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trig_reg     <= 1'b0;
         running_reg  <= 1'b0;
         captured_reg <= 1'b0;
         latched_reg  <= 32'h00000000;
         count_reg    <= 16'h0000;
      end else begin
         trig_reg     <= trig_next;
         running_reg  <= running_next;
         captured_reg <= captured_next;
         latched_reg  <= latched_next;
         count_reg    <= count_next;
      end
   end

   assign ch.captured = captured_reg;
   assign ch.running  = running_reg;
   assign ch.latched  = latched_reg;
   assign ch.count    = count_reg;

   chk_once_stops: assert property (@(posedge clk) disable iff (!rst_b)
      (running_reg && hit && !ch.rearm && ch.mode == 2'(capture_pkg::arm_once))
      |=> !running_reg && captured_reg) else $error("single shot kept running");
   chk_cont_runs: assert property (@(posedge clk) disable iff (!rst_b)
      (running_reg && hit && !ch.rearm && ch.mode == 2'(capture_pkg::arm_continuous))
      |=> running_reg && latched_reg == $past(ch.position)) else $error("continuous lost");
   chk_idle_holds: assert property (@(posedge clk) disable iff (!rst_b)
      (!running_reg && !ch.rearm) |=> $stable(latched_reg) && $stable(count_reg))
      else $error("idle channel changed");
   chk_arm_clears: assert property (@(posedge clk) disable iff (!rst_b)
      ch.rearm |=> !captured_reg) else $error("arm did not clear status");
   chk_count_step: assert property (@(posedge clk) disable iff (!rst_b)
      (running_reg && hit && !ch.rearm) |=> count_reg == $past(count_reg) + 16'h0001)
      else $error("counter did not step");
endmodule

/* hw/capture_if.sv */
`timescale 1ns/1ps
interface capture_if;
   logic        rearm;
   logic        edge_rising;
   logic [1:0]  mode;
   logic        trig;
   logic [31:0] position;
   logic        captured;
   logic        running;
   logic [31:0] latched;
   logic [15:0] count;
   modport top (output rearm, edge_rising, mode, trig, position,
                input captured, running, latched, count);
   modport chan (input rearm, edge_rising, mode, trig, position,
                 output captured, running, latched, count);
endinterface

/* hw/capture_pkg.sv */
package capture_pkg;
   // register offsets (16-bit parameter addresses)
   localparam logic [15:0] status_offset   = 16'h0a02;
   localparam logic [15:0] edge1_offset    = 16'h0a04;
   localparam logic [15:0] edge2_offset    = 16'h0a06;
   localparam logic [15:0] arm1_offset     = 16'h0a08;
   localparam logic [15:0] arm2_offset     = 16'h0a0a;
   localparam logic [15:0] pos1_lo_offset  = 16'h0a0c;
   localparam logic [15:0] pos1_hi_offset  = 16'h0a0e;
   localparam logic [15:0] pos2_lo_offset  = 16'h0a10;
   localparam logic [15:0] pos2_hi_offset  = 16'h0a12;
   localparam logic [15:0] count1_offset   = 16'h0a14;
   localparam logic [15:0] count2_offset   = 16'h0a16;
   // field positions and reset values
   localparam int          edge_bit        = 0;
   localparam logic        edge_reset      = 1'h0;
   localparam logic [15:0] edge_falling    = 16'h0000;
   localparam logic [15:0] edge_rising     = 16'h0001;
   typedef enum logic [1:0] {
      arm_stop       = 2'h0,
      arm_once       = 2'h1,
      arm_continuous = 2'h2
   } arm_mode_t;
   localparam arm_mode_t   arm_reset       = arm_stop;
endpackage

/* hw/position_capture_unit.sv */
`timescale 1ns/1ps
// Function
// - two independent channels latch motor position on a qualifying input edge
// - edge select: 0 falling, 1 rising, default 0, effective immediately
// - arm mode: 0 cancel, 1 single shot, 2 continuous, effective immediately
// - single shot latches first edge after arming then stops
// - continuous overwrites latched position on every edge until cancelled
// - status word bit 0 channel one captured, bit 1 channel two
// - each channel holds signed 32-bit latched position readable by software
// - 16-bit event counter per channel, increments per capture, cleared on arming
module position_capture_unit (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // parameter access port
   input  wire logic        par_wr,
   input  wire logic        par_rd,
   input  wire logic [15:0] par_addr,
   input  wire logic [15:0] par_wdata,
   output logic      [15:0] par_rdata,
   output logic             par_ack,
   output logic             par_err,
   // trigger inputs and motor position
   input  wire logic        trigger_input_one,
   input  wire logic        trigger_input_two,
   input  wire logic [31:0] motor_position
);
   logic [1:0]  edge_reg,  edge_next;
   logic [1:0]  mode1_reg, mode1_next;
   logic [1:0]  mode2_reg, mode2_next;
   logic [1:0]  rearm_reg, rearm_next;
   logic [15:0] rdata_reg, rdata_next;
   logic        ack_reg,   ack_next;
   logic        err_reg,   err_next;

   capture_if ch1 ();
   capture_if ch2 ();

   // decode shared by read and write paths
   function automatic logic known(input logic [15:0] a);
      known = (a == capture_pkg::status_offset) || (a == capture_pkg::edge1_offset)
           || (a == capture_pkg::edge2_offset)  || (a == capture_pkg::arm1_offset)
           || (a == capture_pkg::arm2_offset)   || (a == capture_pkg::pos1_lo_offset)
           || (a == capture_pkg::pos1_hi_offset) || (a == capture_pkg::pos2_lo_offset)
           || (a == capture_pkg::pos2_hi_offset) || (a == capture_pkg::count1_offset)
           || (a == capture_pkg::count2_offset);
   endfunction

   function automatic logic valid_mode(input logic [15:0] d);
      valid_mode = (d <= 16'(capture_pkg::arm_continuous));
   endfunction

   always_comb begin
      edge_next  = edge_reg;
      mode1_next = mode1_reg;
      mode2_next = mode2_reg;
      rearm_next = 2'b00;
      rdata_next = rdata_reg;
      ack_next   = par_wr | par_rd;
      err_next   = (par_wr | par_rd) & ~known(par_addr);
      if (par_wr) begin
         // out-of-range values are refused and flagged, setting kept
         case (par_addr)
            capture_pkg::edge1_offset: begin
               if (par_wdata <= capture_pkg::edge_rising) begin
                  edge_next[0] = par_wdata[capture_pkg::edge_bit];
               end else begin
                  err_next = 1'b1;
               end
            end
            capture_pkg::edge2_offset: begin
               if (par_wdata <= capture_pkg::edge_rising) begin
                  edge_next[1] = par_wdata[capture_pkg::edge_bit];
               end else begin
                  err_next = 1'b1;
               end
            end
            capture_pkg::arm1_offset: begin
               if (valid_mode(par_wdata)) begin
                  mode1_next    = par_wdata[1:0];
                  rearm_next[0] = 1'b1;
               end else begin
                  err_next = 1'b1;
               end
            end
            capture_pkg::arm2_offset: begin
               if (valid_mode(par_wdata)) begin
                  mode2_next    = par_wdata[1:0];
                  rearm_next[1] = 1'b1;
               end else begin
                  err_next = 1'b1;
               end
            end
            capture_pkg::status_offset: err_next = 1'b1;
            default: err_next = err_next | known(par_addr);
         endcase
      end else if (par_rd) begin
         case (par_addr)
            capture_pkg::status_offset:  rdata_next = {14'h0000, ch2.captured, ch1.captured};
            capture_pkg::edge1_offset:   rdata_next = {15'h0000, edge_reg[0]};
            capture_pkg::edge2_offset:   rdata_next = {15'h0000, edge_reg[1]};
            capture_pkg::arm1_offset:    rdata_next = {14'h0000, mode1_reg};
            capture_pkg::arm2_offset:    rdata_next = {14'h0000, mode2_reg};
            capture_pkg::pos1_lo_offset: rdata_next = ch1.latched[15:0];
            capture_pkg::pos1_hi_offset: rdata_next = ch1.latched[31:16];
            capture_pkg::pos2_lo_offset: rdata_next = ch2.latched[15:0];
            capture_pkg::pos2_hi_offset: rdata_next = ch2.latched[31:16];
            capture_pkg::count1_offset:  rdata_next = ch1.count;
            capture_pkg::count2_offset:  rdata_next = ch2.count;
            default:                     rdata_next = 16'h0000;
         endcase
      end
      // a finished single shot reads back as stopped; an arm write in the
      // same cycle must win, or the freshly written mode would be lost
      if (!rearm_reg[0] && !rearm_next[0] && !ch1.running
          && mode1_reg == 2'(capture_pkg::arm_once) && ch1.captured) begin
         mode1_next = 2'(capture_pkg::arm_stop);
      end
      if (!rearm_reg[1] && !rearm_next[1] && !ch2.running
          && mode2_reg == 2'(capture_pkg::arm_once) && ch2.captured) begin
         mode2_next = 2'(capture_pkg::arm_stop);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         edge_reg  <= {2{capture_pkg::edge_reset}};
         mode1_reg <= 2'(capture_pkg::arm_reset);
         mode2_reg <= 2'(capture_pkg::arm_reset);
         rearm_reg <= 2'b00;
         rdata_reg <= 16'h0000;
         ack_reg   <= 1'b0;
         err_reg   <= 1'b0;
      end else begin
         edge_reg  <= edge_next;
         mode1_reg <= mode1_next;
         mode2_reg <= mode2_next;
         rearm_reg <= rearm_next;
         rdata_reg <= rdata_next;
         ack_reg   <= ack_next;
         err_reg   <= err_next;
      end
   end

   assign par_rdata = rdata_reg;
   assign par_ack   = ack_reg;
   assign par_err   = err_reg;

   assign ch1.rearm       = rearm_reg[0];
   assign ch1.edge_rising = edge_reg[0];
   assign ch1.mode        = mode1_reg;
   assign ch1.trig        = trigger_input_one;
   assign ch1.position    = motor_position;
   assign ch2.rearm       = rearm_reg[1];
   assign ch2.edge_rising = edge_reg[1];
   assign ch2.mode        = mode2_reg;
   assign ch2.trig        = trigger_input_two;
   assign ch2.position    = motor_position;

   capture_channel u_ch1 (
      .clk   (clk),
      .rst_b (rst_b),
      .ch    (ch1)
   );
   capture_channel u_ch2 (
      .clk   (clk),
      .rst_b (rst_b),
      .ch    (ch2)
   );

   // an arm write restarts the channel two edges later in the written mode
   chk_arm_cmd: assert property (@(posedge clk) disable iff (!rst_b)
      (par_wr && par_addr == capture_pkg::arm1_offset && par_wdata <= 16'h0002)
      |=> rearm_reg[0] ##1 ch1.running == ($past(mode1_reg) != 2'h0))
      else $error("arm write not applied");

   chk_arm2_cmd: assert property (@(posedge clk) disable iff (!rst_b)
      (par_wr && par_addr == capture_pkg::arm2_offset && par_wdata <= 16'h0002)
      |=> rearm_reg[1] ##1 ch2.running == ($past(mode2_reg) != 2'h0))
      else $error("arm two write not applied");

   // refused mode values neither arm nor cancel
   chk_mode_refuse: assert property (@(posedge clk) disable iff (!rst_b)
      (par_wr && par_wdata > 16'h0002
       && (par_addr == capture_pkg::arm1_offset || par_addr == capture_pkg::arm2_offset))
      |=> par_err && rearm_reg == 2'b00) else $error("bad mode accepted");

   chk_status_map: assert property (@(posedge clk) disable iff (!rst_b)
      (par_rd && !par_wr && par_addr == capture_pkg::status_offset)
      |=> par_rdata[1:0] == $past({ch2.captured, ch1.captured}) && par_ack)
      else $error("status word wrong");

   chk_status_ro: assert property (@(posedge clk) disable iff (!rst_b)
      (par_wr && par_addr == capture_pkg::status_offset) |=> par_err && par_ack)
      else $error("status write not refused");

   chk_edge_write: assert property (@(posedge clk) disable iff (!rst_b)
      (par_wr && par_addr == capture_pkg::edge2_offset && par_wdata == 16'h0001)
      |=> edge_reg[1]) else $error("edge select not taken");

   chk_edge_refuse: assert property (@(posedge clk) disable iff (!rst_b)
      (par_wr && par_addr == capture_pkg::edge1_offset && par_wdata > 16'h0001)
      |=> par_err && $stable(edge_reg)) else $error("bad edge value accepted");

   // the readback clears once, and only when no new arm write is pending
   chk_once_readback: assert property (@(posedge clk) disable iff (!rst_b)
      (!rearm_reg[0] && !rearm_next[0] && !ch1.running && ch1.captured
       && mode1_reg == 2'(capture_pkg::arm_once))
      |=> mode1_reg == 2'(capture_pkg::arm_stop)) else $error("finished shot not stopped");

   chk_pos_read: assert property (@(posedge clk) disable iff (!rst_b)
      (par_rd && !par_wr && par_addr == capture_pkg::pos1_hi_offset)
      |=> par_rdata == $past(ch1.latched[31:16])) else $error("position word wrong");

   chk_count_read: assert property (@(posedge clk) disable iff (!rst_b)
      (par_rd && !par_wr && par_addr == capture_pkg::count2_offset)
      |=> par_rdata == $past(ch2.count)) else $error("counter word wrong");

   // every access is answered exactly one cycle later, never twice
   chk_ack_pulse: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> par_ack == $past(par_wr || par_rd)) else $error("answer not one cycle later");

   chk_unmapped_err: assert property (@(posedge clk) disable iff (!rst_b)
      (par_rd && !par_wr && !known(par_addr)) |=> par_err && par_rdata == 16'h0000)
      else $error("unmapped read not refused");
endmodule

/* tb/motor_model.sv */
`timescale 1ns/1ps
module motor_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // position preset
   input  wire logic        load,
   input  wire logic [31:0] load_value,
   // shaft position
   output logic      [31:0] position
);
   // keeps ramping, so a capture one cycle late reads a different value
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         position <= 32'h0;
      end else if (load) begin
         position <= load_value;
      end else begin
         position <= position + 32'h1;
      end
   end
endmodule

/* tb/position_capture_unit_tb.sv */
`timescale 1ns/1ps
module position_capture_unit_tb;
   logic        clk, rst_b, par_wr, par_rd, par_ack, par_err, t1, t2, ld;
   logic [15:0] par_addr, par_wdata, par_rdata;
   logic [31:0] ldv, pos;
   int          fails, samples_checked;

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   position_capture_unit u_position_capture_unit (
      .clk(clk), .rst_b(rst_b), .par_wr(par_wr), .par_rd(par_rd),
      .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
      .par_ack(par_ack), .par_err(par_err), .trigger_input_one(t1),
      .trigger_input_two(t2), .motor_position(pos));
   motor_model u_motor_model (
      .clk(clk), .rst_b(rst_b), .load(ld), .load_value(ldv), .position(pos));

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one access; ack, err and read data are judged in the answer cycle
   task acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic e);
      @(posedge clk);
      par_wr <= wr;
      par_rd <= !wr;
      par_addr <= a;
      par_wdata <= d;
      @(posedge clk);
      par_wr <= 1'h0;
      par_rd <= 1'h0;
      @(negedge clk);
      chk({14'h0, par_ack, par_err, wr ? 16'h0 : par_rdata},
          {14'h0, 1'h1, e, wr ? 16'h0 : d});
   endtask

   // new input level; the ramp is preset so the edge cycle sees v
   task trig(input logic ch, input logic lvl, input logic [31:0] v);
      @(posedge clk);
      ld <= 1'h1;
      ldv <= v;
      @(posedge clk);
      ld <= 1'h0;
      if (ch) t2 <= lvl;
      else t1 <= lvl;
      repeat (3) @(posedge clk);
   endtask

   task t_reset;
      acc(1'h0, capture_pkg::status_offset, 16'h0, 1'h0);
      acc(1'h0, capture_pkg::edge1_offset, 16'h0, 1'h0);
      acc(1'h0, capture_pkg::arm2_offset, 16'h0, 1'h0);
      $display("test reset values done");
   endtask

   task t_once;
      acc(1'h1, capture_pkg::edge1_offset, 16'h1, 1'h0);
      acc(1'h1, capture_pkg::arm1_offset, 16'h1, 1'h0);
      trig(1'h0, 1'h1, 32'hfffff123);
      trig(1'h0, 1'h0, 32'h00000555);
      trig(1'h0, 1'h1, 32'h00000777);
      acc(1'h0, capture_pkg::pos1_lo_offset, 16'hf123, 1'h0);
      acc(1'h0, capture_pkg::pos1_hi_offset, 16'hffff, 1'h0);
      acc(1'h0, capture_pkg::count1_offset, 16'h1, 1'h0);
      acc(1'h0, capture_pkg::status_offset, 16'h1, 1'h0);
      acc(1'h0, capture_pkg::arm1_offset, 16'h0, 1'h0);
      $display("test single shot done");
   endtask

   task t_cont;
      acc(1'h1, capture_pkg::arm2_offset, 16'h2, 1'h0);
      trig(1'h1, 1'h1, 32'h00000100);
      trig(1'h1, 1'h0, 32'h12345678);
      trig(1'h1, 1'h1, 32'h00000200);
      trig(1'h1, 1'h0, 32'h8000abcd);
      acc(1'h0, capture_pkg::pos2_lo_offset, 16'habcd, 1'h0);
      acc(1'h0, capture_pkg::pos2_hi_offset, 16'h8000, 1'h0);
      acc(1'h0, capture_pkg::count2_offset, 16'h2, 1'h0);
      acc(1'h0, capture_pkg::status_offset, 16'h3, 1'h0);
      $display("test continuous done");
   endtask

   task t_cancel;
      acc(1'h1, capture_pkg::arm2_offset, 16'h0, 1'h0);
      acc(1'h0, capture_pkg::status_offset, 16'h1, 1'h0);
      trig(1'h1, 1'h1, 32'h00000300);
      trig(1'h1, 1'h0, 32'h00000400);
      acc(1'h0, capture_pkg::pos2_lo_offset, 16'habcd, 1'h0);
      acc(1'h1, capture_pkg::arm1_offset, 16'h1, 1'h0);
      acc(1'h0, capture_pkg::count1_offset, 16'h0, 1'h0);
      acc(1'h0, capture_pkg::status_offset, 16'h0, 1'h0);
      acc(1'h1, capture_pkg::arm1_offset, 16'h0, 1'h0);
      $display("test cancel and rearm done");
   endtask

   task t_refuse;
      acc(1'h1, capture_pkg::edge1_offset, 16'h2, 1'h1);
      acc(1'h0, capture_pkg::edge1_offset, 16'h1, 1'h0);
      acc(1'h1, capture_pkg::arm2_offset, 16'h3, 1'h1);
      acc(1'h1, capture_pkg::status_offset, 16'h3, 1'h1);
      acc(1'h0, 16'h0a20, 16'h0, 1'h1);
      $display("test refusals done");
   endtask

   // reset in mid-run must bring back the defaults; edge one, position two low, counter two and status are read back
   task t_midreset;
      @(posedge clk);
      rst_b <= 1'h0;
      repeat (3) @(posedge clk);
      rst_b <= 1'h1;
      acc(1'h0, capture_pkg::edge1_offset, 16'h0, 1'h0);
      acc(1'h0, capture_pkg::pos2_lo_offset, 16'h0, 1'h0);
      acc(1'h0, capture_pkg::count2_offset, 16'h0, 1'h0);
      acc(1'h0, capture_pkg::status_offset, 16'h0, 1'h0);
      $display("test mid-run reset done");
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      test_done;
   end

   initial begin
      {rst_b, par_wr, par_rd, t1, t2, ld} = 6'h0;
      {par_addr, par_wdata, ldv} = 64'h0;
      repeat (3) @(posedge clk);
      rst_b <= 1'h1;
      t_reset;
      t_once;
      t_cont;
      t_cancel;
      t_refuse;
      t_midreset;
      test_done;
   end
endmodule
